// ### hw/frg_map.vh
`ifndef FRG_MAP_VH
`define FRG_MAP_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FRG_OFS_CTRL      8'h00
`define FRG_OFS_LOCK      8'h04
`define FRG_OFS_STATUS    8'h08
`define FRG_OFS_CFG       8'h0C
// ----------------------------------------------------------------
// ctrl fields (write pulses)
// ----------------------------------------------------------------
`define FRG_CTRL_REENABLE 0
`define FRG_CTRL_ERASE    1
// ----------------------------------------------------------------
// lock register fields
// ----------------------------------------------------------------
`define FRG_LOCK_APP_LO   0
`define FRG_LOCK_APP_HI   1
`define FRG_LOCK_BOOT_LO  2
`define FRG_LOCK_BOOT_HI  3
`define FRG_LOCK_RESET    4'hF
// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define FRG_ST_BUSY       0
`define FRG_ST_HALT       1
`define FRG_ST_PROG       2
`define FRG_ST_INTOFF     3
// ----------------------------------------------------------------
// cfg fields
// ----------------------------------------------------------------
`define FRG_CFG_VEC_BOOT  0
`define FRG_CFG_RESET     1'h0
// ----------------------------------------------------------------
// timing: programming time in us at 10 MHz
// ----------------------------------------------------------------
`define FRG_PROG_US       4
`define FRG_CLK_MHZ       10
`define FRG_PROG_CYC      (`FRG_PROG_US * `FRG_CLK_MHZ)
`define FRG_AXI_OKAY      2'h0
`define FRG_AXI_SLVERR    2'h2
`endif

// ### hw/frg_guard.v
`timescale 1ns/100ps
`include "frg_map.vh"
module frg_guard #(
    parameter AW        = 16,
    parameter STALLING_REGION_BASE = 16'hE000,
    parameter PROG_CYC  = `FRG_PROG_CYC
) (
    // clock and reset
    input  wire          aclk,
    input  wire          aresetn,
    // axi4-lite write
    input  wire [7:0]    s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output wire          s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output wire          s_axi_wready,
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    // axi4-lite read
    input  wire [7:0]    s_axi_araddr,
    input  wire          s_axi_arvalid,
    output wire          s_axi_arready,
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready,
    // boot section base address from fuses
    input  wire [AW-1:0] boot_base,
    // cpu store/load requests
    input  wire          store_req,
    input  wire          store_is_load,
    input  wire [AW-1:0] store_addr,
    input  wire          load_req,
    input  wire [AW-1:0] load_addr,
    input  wire [AW-1:0] fetch_pc,
    input  wire          gen_lock_in,
    // results to cpu and flash
    output reg           flash_write,
    output reg           flash_load,
    output reg  [AW-1:0] flash_addr,
    output reg           load_grant,
    output wire          cpu_halt,
    output wire          conc_read_valid,
    output wire          irq_disable
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam S_IDLE = 3'b001;
    localparam S_CONC = 3'b010;
    localparam S_STAL = 3'b100;
    reg [2:0]  st_q;
    reg [2:0]  st_d;
    reg [15:0] cnt_q;
    reg        busy_q;
    reg [3:0]  lock_q;
    reg        vec_boot_q;
    reg        in_boot_q;
    reg [AW-1:0] prog_addr_q;
    // axi write capture, declared here because the busy clear reads it
    reg        aw_q;
    reg        w_q;
    reg [7:0]  awa_q;
    reg [31:0] wd_q;
    reg [3:0]  ws_q;
    wire       do_wr = aw_q & w_q & ~s_axi_bvalid;
    wire       wr_reenable = do_wr & (awa_q == `FRG_OFS_CTRL) & ws_q[0] & wd_q[`FRG_CTRL_REENABLE];
    // ----------------------------------------------------------------
    // address classification
    // ----------------------------------------------------------------
    // boot base is clamped so the boot section never leaves the stalling region
    wire [AW-1:0] boot_lim = (boot_base < STALLING_REGION_BASE) ? STALLING_REGION_BASE : boot_base;
    wire st_in_boot  = store_addr >= boot_lim;
    wire ld_in_boot  = load_addr  >= boot_lim;
    wire pc_in_boot  = fetch_pc   >= boot_lim;
    wire st_in_stall = store_addr >= STALLING_REGION_BASE;
    // gen_lock_in is deliberately never read in any permission term
    wire app_lo  = lock_q[`FRG_LOCK_APP_LO];
    wire app_hi  = lock_q[`FRG_LOCK_APP_HI];
    wire boot_lo = lock_q[`FRG_LOCK_BOOT_LO];
    wire boot_hi = lock_q[`FRG_LOCK_BOOT_HI];
    // a bit at zero means programmed
    wire app_wr_deny   = ~app_lo;
    wire app_rd_deny   = ~app_hi;
    wire boot_wr_deny  = ~boot_lo;
    wire boot_rd_deny  = ~boot_hi;
    wire wr_deny = st_in_boot ? boot_wr_deny : app_wr_deny;
    // loads are only restricted when reaching across sections
    wire rd_deny = (ld_in_boot & ~pc_in_boot & boot_rd_deny)
                 | (~ld_in_boot & pc_in_boot & app_rd_deny);
    wire start = store_req & ~store_is_load & (st_q == S_IDLE) & ~wr_deny;
    // ----------------------------------------------------------------
    // programming sequencer
    // ----------------------------------------------------------------
    always @* begin
        st_d = st_q;
        case (st_q)
            S_IDLE: begin
                if (start)
                    st_d = st_in_stall ? S_STAL : S_CONC;
            end
            S_CONC, S_STAL: begin
                if (cnt_q == 16'h0001)
                    st_d = S_IDLE;
            end
            default: st_d = S_IDLE;
        endcase
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            st_q        <= S_IDLE;
            cnt_q       <= 16'h0000;
            busy_q      <= 1'b0;
            prog_addr_q <= {AW{1'b0}};
            flash_write <= 1'b0;
            flash_load  <= 1'b0;
            flash_addr  <= {AW{1'b0}};
            load_grant  <= 1'b0;
            in_boot_q   <= 1'b0;
        end else begin
            st_q        <= st_d;
            in_boot_q   <= pc_in_boot;
            // denied writes never reach the flash and give no error
            flash_write <= start;
            flash_load  <= store_req & store_is_load & (st_q == S_IDLE);
            load_grant  <= load_req & ~rd_deny;
            if (start | (store_req & store_is_load))
                flash_addr <= store_addr;
            if (start) begin
                cnt_q       <= PROG_CYC[15:0];
                prog_addr_q <= store_addr;
            end else if (cnt_q != 16'h0000) begin
                cnt_q <= cnt_q - 16'h0001;
            end
            // set wins over clear
            if (start & ~st_in_stall)
                busy_q <= 1'b1;
            else if ((st_q == S_IDLE) & (wr_reenable | (store_req & store_is_load)))
                busy_q <= 1'b0;
        end
    end
    // cpu keeps running in concurrent mode, stalls on stalling region
    assign cpu_halt = (st_q == S_STAL);
    // concurrent region unreadable while busy
    assign conc_read_valid = ~busy_q & (st_q != S_STAL);
    // interrupt mask when vectors sit in the other section and the running section's read lock bit is programmed
    assign irq_disable = (vec_boot_q & ~in_boot_q & ~app_rd_deny ? 1'b0 : vec_boot_q & ~in_boot_q)
                       | (~vec_boot_q & in_boot_q & boot_rd_deny);
    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            awa_q        <= 8'h00;
            wd_q         <= 32'h00000000;
            ws_q         <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `FRG_AXI_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `FRG_AXI_OKAY;
            s_axi_rdata  <= 32'h00000000;
            lock_q       <= `FRG_LOCK_RESET;
            vec_boot_q   <= `FRG_CFG_RESET;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_q  <= 1'b1;
                awa_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_q  <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_q         <= 1'b0;
                w_q          <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `FRG_AXI_OKAY;
                case (awa_q)
                    `FRG_OFS_CTRL: begin
                        // chip erase and reset are the only ways back to unprogrammed
                        if (ws_q[0] & wd_q[`FRG_CTRL_ERASE])
                            lock_q <= `FRG_LOCK_RESET;
                    end
                    `FRG_OFS_LOCK: begin
                        // software may only program bits, never clear them
                        if (ws_q[0])
                            lock_q <= lock_q & wd_q[3:0];
                    end
                    `FRG_OFS_CFG: begin
                        if (ws_q[0])
                            vec_boot_q <= wd_q[`FRG_CFG_VEC_BOOT];
                    end
                    `FRG_OFS_STATUS: begin
                    end
                    default: s_axi_bresp <= `FRG_AXI_SLVERR;
                endcase
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `FRG_AXI_OKAY;
                case (s_axi_araddr)
                    `FRG_OFS_CTRL:   s_axi_rdata <= 32'h00000000;
                    `FRG_OFS_LOCK:   s_axi_rdata <= {28'h0000000, lock_q};
                    `FRG_OFS_STATUS: s_axi_rdata <= {28'h0000000, irq_disable, (st_q != S_IDLE),
                                                      cpu_halt, busy_q};
                    `FRG_OFS_CFG:    s_axi_rdata <= {31'h00000000, vec_boot_q};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `FRG_AXI_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // frg_guard

// ### bench/frg_guard_monitor.sv
`timescale 1ns/100ps
module frg_guard_monitor #(
    parameter AW        = 16,
    parameter STALLING_REGION_BASE = 16'hE000
) (
    // clock and reset
    input logic          aclk,
    input logic          aresetn,
    // cpu requests
    input logic          store_req,
    input logic          store_is_load,
    input logic [AW-1:0] store_addr,
    input logic          load_req,
    // guard results
    input logic          flash_write,
    input logic          flash_load,
    input logic [AW-1:0] flash_addr,
    input logic          load_grant,
    input logic          cpu_halt,
    input logic          conc_read_valid
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // a stall lasts the whole programming time, short counts in sim
    sequence s_halt_run;
        cpu_halt [*4];
    endsequence
    chk_halt_span:
        assert property ($rose(cpu_halt) |-> s_halt_run ##[1:8] !cpu_halt) else $error("halt span");
    chk_halt_cause:
        assert property ($rose(cpu_halt) |-> flash_write && flash_addr >= STALLING_REGION_BASE) else $error("halt cause");
    chk_conc_run:
        assert property (flash_write && flash_addr < STALLING_REGION_BASE |-> !cpu_halt && !conc_read_valid)
        else $error("conc run");
    chk_halt_blocks:
        assert property (cpu_halt |-> !conc_read_valid) else $error("halt blocks");
    chk_write_cause:
        assert property (flash_write |-> $past(store_req) && !$past(store_is_load) && flash_addr == $past(store_addr))
        else $error("write cause");
    chk_load_cause:
        assert property (flash_load |-> $past(store_req) && $past(store_is_load)) else $error("load cause");
    chk_busy_clear:
        assert property (flash_load && !cpu_halt |-> ##[0:1] conc_read_valid) else $error("busy clear");
    chk_grant_cause:
        assert property (load_grant |-> $past(load_req)) else $error("grant cause");
endmodule // frg_guard_monitor

// ### bench/frg_cpu_model.sv
`timescale 1ns/100ps
module frg_cpu_model #(
    parameter AW = 16
) (
    // clock and stall
    input  logic          aclk,
    input  logic          cpu_halt,
    // requests to the guard
    output logic          store_req,
    output logic          store_is_load,
    output logic [AW-1:0] store_addr,
    output logic          load_req,
    output logic [AW-1:0] load_addr,
    output logic [AW-1:0] fetch_pc
);
    initial begin
        {store_req, store_is_load, load_req, store_addr, load_addr} = '0;
        fetch_pc = 16'hF000;
    end
    // a halted core issues no store or load until the stall ends
    task automatic run;
        @(posedge aclk);
        while (cpu_halt)
            @(posedge aclk);
    endtask
    // released address lines show a new pattern, not the old value
    task automatic store(input logic [AW-1:0] a, input logic pl);
        run;
        store_req     <= 1'b1;
        store_is_load <= pl;
        store_addr    <= a;
        @(posedge aclk);
        store_req     <= 1'b0;
        store_addr    <= ~a;
        #1;
    endtask
    task automatic load(input logic [AW-1:0] a);
        run;
        load_req  <= 1'b1;
        load_addr <= a;
        @(posedge aclk);
        load_req  <= 1'b0;
        load_addr <= ~a;
        #1;
    endtask
    task automatic jump(input logic [AW-1:0] pc);
        @(posedge aclk);
        fetch_pc <= pc;
        #1;
    endtask
endmodule // frg_cpu_model

// ### bench/frg_guard_test.sv
`timescale 1ns/100ps
module frg_guard_test;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] boot_base, store_addr, load_addr, fetch_pc, flash_addr;
    logic        store_req, store_is_load, load_req, gen_lock_in, flash_write, flash_load;
    logic        load_grant, cpu_halt, conc_read_valid, irq_disable;
    int          fail_count = 0, samples_checked = 0;
    always #50 aclk = ~aclk;
    frg_guard #(.PROG_CYC(5)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .boot_base,
        .store_req, .store_is_load, .store_addr, .load_req, .load_addr, .fetch_pc, .gen_lock_in, .flash_write,
        .flash_load, .flash_addr, .load_grant, .cpu_halt, .conc_read_valid, .irq_disable);
    frg_cpu_model cpu (.aclk, .cpu_halt, .store_req, .store_is_load, .store_addr, .load_req, .load_addr, .fetch_pc);
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        {rdat, resp} = {s_axi_rdata, s_axi_rresp};
    endtask
    task automatic t_regs;
        rd(8'h08);
        chk("status", rdat[3:0], 0);
        rd(8'h04);
        chk("lock", rdat[3:0], 4'hF);
        rd(8'h10);
        chk("resp", resp, 2'h2);
    endtask
    // boot base below the stalling region must be pulled up to it
    task automatic t_conc;
        boot_base <= 16'h8000;
        wr(8'h04, 32'hB);
        cpu.store(16'h9000, 1'b0);
        chk("write", flash_write, 1);
        chk("halt", cpu_halt, 0);
        chk("valid", conc_read_valid, 0);
        rd(8'h08);
        chk("busy", rdat[0], 1);
        repeat (10) @(posedge aclk);
        rd(8'h08);
        chk("busy", rdat[2:0], 3'h1);
        wr(8'h00, 32'h1);
        chk("valid", conc_read_valid, 1);
        cpu.store(16'h2000, 1'b0);
        repeat (10) @(posedge aclk);
        chk("valid", conc_read_valid, 0);
        cpu.store(16'h0000, 1'b1);
        chk("valid", conc_read_valid, 1);
    endtask
    task automatic t_stall;
        boot_base <= 16'hF000;
        cpu.store(16'hE800, 1'b0);
        chk("halt", cpu_halt, 1);
        chk("valid", conc_read_valid, 0);
        rd(8'h08);
        chk("halt", rdat[1], 1);
    endtask
    // the core stays in boot code while storing, away from blocked code
    task automatic t_locks;
        logic [1:0] v;
        logic [3:0] lk;
        gen_lock_in <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            for (int m = 0; m < 4; m++) begin
                v  = m[1:0];
                lk = s ? {v, 2'h3} : {2'h3, v};
                wr(8'h00, 32'h2);
                wr(8'h04, {28'h0, lk});
                wr(8'h04, 32'hF);
                rd(8'h04);
                chk("lock", rdat[3:0], lk);
                cpu.jump(16'hF000);
                cpu.store(s ? 16'hF100 : 16'hE100, 1'b0);
                chk("write", flash_write, v[0]);
                cpu.jump(s ? 16'h0100 : 16'hF000);
                cpu.load(s ? 16'hF100 : 16'h0100);
                chk("read", load_grant, v[1]);
                wr(8'h0C, {31'h0, ~s[0]});
                cpu.jump(s ? 16'hF000 : 16'h0100);
                // the section flag follows the new pc one edge later
                @(posedge aclk);
                #1;
                chk("irq", irq_disable, {~v[1]});
            end
        end
    endtask
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, gen_lock_in} = '0;
        s_axi_wstrb = 4'hF;
        boot_base = 16'hF000;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_conc;
        t_stall;
        t_locks;
        final_report;
    end
    // about seventeen times the expected run
    initial begin
        repeat (5000) @(posedge aclk);
        fail_count++;
        final_report;
    end
endmodule // frg_guard_test
bind frg_guard frg_guard_monitor #(.AW(AW), .STALLING_REGION_BASE(STALLING_REGION_BASE)) u_mon (.aclk, .aresetn, .store_req,
    .store_is_load, .store_addr, .load_req, .flash_write, .flash_load, .flash_addr, .load_grant, .cpu_halt,
    .conc_read_valid);
